/* File: ddr2_strobe_pkg.sv */
// shared constants and types for the two-rank ddr2 strobe datapath
package ddr2_strobe_pkg;
    localparam int          RANKS                   = 2;
    localparam int          BURST_BEATS             = 4;
    localparam logic [2:0]  CMD_LOAD_MODE           = 3'h0;
    localparam logic [2:0]  CMD_WRITE               = 3'h4;
    localparam logic [2:0]  CMD_READ                = 3'h5;
    localparam logic [2:0]  EXT_CONFIG_BANK         = 3'h1;
    localparam int          COMPLEMENT_DISABLE_POS  = 10;
    localparam int          REDUNDANT_ENABLE_POS    = 11;
    localparam logic        COMPLEMENT_DISABLE_RST  = 1'b1;
    localparam logic        REDUNDANT_ENABLE_RST    = 1'b0;
    localparam int          LINK_CLK_PERIOD_NS      = 400;
    localparam int          WRITE_TIMEOUT_EDGES     = 8;
    localparam logic [2:0]  READ_RELEASE_PHASE      = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_READ,
        ST_WRITE
    } burst_state_t;
endpackage

/* File: ddr2_pin_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module ddr2_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_reset,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("ddr2_pin_sync needs at least one bit");
        end
    endgenerate

    // first stage feeds only the second stage
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule // ddr2_pin_sync

/* File: ddr2_two_rank_strobe_datapath.sv */
// two-rank ddr2 data strobe and burst datapath, device side
`timescale 1ns/1ns
module ddr2_two_rank_strobe_datapath
    import ddr2_strobe_pkg::*;
#(
    parameter int DQ_WIDTH   = 8,
    parameter int INDEX_BITS = 5
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_reset,
    input  wire logic                i_ck,
    input  wire logic [RANKS-1:0]    i_cs_n,
    input  wire logic                i_ras_n,
    input  wire logic                i_cas_n,
    input  wire logic                i_we_n,
    input  wire logic [2:0]          i_ba,
    input  wire logic [13:0]         i_addr,
    input  wire logic [DQ_WIDTH-1:0] i_dq,
    output logic      [DQ_WIDTH-1:0] o_dq,
    output logic                     o_dq_oe,
    input  wire logic                i_dqs,
    output logic                     o_dqs,
    output logic                     o_dqs_oe,
    input  wire logic                i_dqs_complement,
    output logic                     o_dqs_complement,
    output logic                     o_dqs_complement_oe,
    input  wire logic                i_write_byte_mask,
    output logic                     o_redundant_read_strobe,
    output logic                     o_redundant_read_strobe_oe,
    input  wire logic                i_redundant_read_strobe_complement,
    output logic                     o_redundant_read_strobe_complement,
    output logic                     o_redundant_read_strobe_complement_oe,
    output logic      [RANKS-1:0]    o_strobe_complement_enabled,
    output logic      [RANKS-1:0]    o_redundant_strobe_enabled,
    output logic                     o_busy
);
    localparam int  WORD_W   = BURST_BEATS * DQ_WIDTH;
    localparam int  DEPTH    = 1 << INDEX_BITS;
    localparam int  COL_BITS = INDEX_BITS - 3;
    localparam bit  IS_X8    = (DQ_WIDTH == 8);
    localparam int  SYNC_W   = 1 + RANKS + 3 + 3 + 14 + DQ_WIDTH + 2;

    generate
        if (!(DQ_WIDTH == 4 || DQ_WIDTH == 8) || INDEX_BITS < 4 || INDEX_BITS > 15) begin : g_bad_params
            $error("DQ_WIDTH must be 4 or 8 and INDEX_BITS 4 to 15");
        end
    endgenerate

    logic [SYNC_W-1:0]   sync_bus;
    logic                ck_s;
    logic [RANKS-1:0]    cs_n_s;
    logic [2:0]          cmd_s;
    logic [2:0]          ba_s;
    logic [13:0]         addr_s;
    logic [DQ_WIDTH-1:0] dq_s;
    logic                dqs_s;
    logic                mask_s;

    ddr2_pin_sync #(
        .WIDTH (SYNC_W)
    ) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_reset    (i_reset),
        .i_async    ({i_ck, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_addr, i_dq, i_dqs, i_write_byte_mask}),
        .o_sync     (sync_bus)
    );

    assign {ck_s, cs_n_s, cmd_s, ba_s, addr_s, dq_s, dqs_s, mask_s} = sync_bus;

    // one word per rank and location; each rank is its own die
    logic [WORD_W-1:0] mem [RANKS][DEPTH];

    burst_state_t          state_reg,      state_next;
    logic [2:0]            phase_reg,      phase_next;
    logic [2:0]            beat_reg,       beat_next;
    logic                  rank_reg,       rank_next;
    logic [INDEX_BITS-1:0] index_reg,      index_next;
    logic [WORD_W-1:0]     rd_word_reg,    rd_word_next;
    logic [WORD_W-1:0]     wr_word_reg,    wr_word_next;
    logic [3:0]            wr_mask_reg,    wr_mask_next;
    logic [RANKS-1:0]      cdis_reg,       cdis_next;
    logic [RANKS-1:0]      rrs_en_reg,     rrs_en_next;
    logic                  ck_prev_reg,    ck_prev_next;
    logic                  dqs_prev_reg,   dqs_prev_next;
    logic [DQ_WIDTH-1:0]   dq_out_reg,     dq_out_next;
    logic                  drive_reg,      drive_next;
    logic                  dqs_out_reg,    dqs_out_next;
    logic                  dqsc_out_reg,   dqsc_out_next;
    logic                  dqsc_oe_reg,    dqsc_oe_next;
    logic                  rrs_oe_reg,     rrs_oe_next;
    logic                  rrsc_oe_reg,    rrsc_oe_next;

    logic                  ck_rise;
    logic                  ck_edge;
    logic                  dqs_edge;
    logic                  cmd_valid;
    logic                  cmd_rank;
    logic [INDEX_BITS-1:0] cmd_index;
    logic                  mem_we;
    logic [WORD_W-1:0]     mem_wdata;

    function automatic logic [WORD_W-1:0] merge_masked(input logic [WORD_W-1:0] old_word,
                                                      input logic [WORD_W-1:0] new_word,
                                                      input logic [3:0]        mask);
        logic [WORD_W-1:0] result;
        result = new_word;
        for (int b = 0; b < BURST_BEATS; b++) begin
            if (mask[b]) begin
                result[b*DQ_WIDTH +: DQ_WIDTH] = old_word[b*DQ_WIDTH +: DQ_WIDTH];
            end
        end
        return result;
    endfunction

    assign ck_rise   = ck_s & ~ck_prev_reg;
    assign ck_edge   = ck_s ^ ck_prev_reg;
    assign dqs_edge  = dqs_s ^ dqs_prev_reg;
    assign cmd_valid = ck_rise & ~(&cs_n_s);
    assign cmd_rank  = cs_n_s[0];
    assign cmd_index = {ba_s, addr_s[COL_BITS+1:2]};

    always_comb begin
        state_next    = state_reg;
        phase_next    = phase_reg;
        beat_next     = beat_reg;
        rank_next     = rank_reg;
        index_next    = index_reg;
        rd_word_next  = rd_word_reg;
        wr_word_next  = wr_word_reg;
        wr_mask_next  = wr_mask_reg;
        cdis_next     = cdis_reg;
        rrs_en_next   = rrs_en_reg;
        ck_prev_next  = ck_s;
        dqs_prev_next = dqs_s;
        dq_out_next   = dq_out_reg;
        drive_next    = drive_reg;
        dqs_out_next  = dqs_out_reg;
        mem_we        = 1'b0;
        mem_wdata     = wr_word_reg;
        case (state_reg)
            ST_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_s)
                        CMD_LOAD_MODE: begin
                            if (ba_s == EXT_CONFIG_BANK) begin
                                for (int r = 0; r < RANKS; r++) begin
                                    if (!cs_n_s[r]) begin
                                        cdis_next[r]    = addr_s[COMPLEMENT_DISABLE_POS];
                                        rrs_en_next[r]  = IS_X8 & addr_s[REDUNDANT_ENABLE_POS];
                                    end
                                end
                            end
                        end
                        CMD_READ: begin
                            state_next   = ST_READ;
                            phase_next   = 3'h0;
                            rank_next    = cmd_rank;
                            rd_word_next = mem[cmd_rank][cmd_index];
                        end
                        CMD_WRITE: begin
                            state_next   = ST_WRITE;
                            phase_next   = 3'h0;
                            beat_next    = 3'h0;
                            rank_next    = cmd_rank;
                            index_next   = cmd_index;
                            wr_mask_next = 4'h0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_READ: begin
                if (ck_edge) begin
                    phase_next = phase_reg + 3'h1;
                    if (phase_reg == 3'h0) begin
                        // preamble: strobe held low for one half cycle
                        drive_next   = 1'b1;
                        dqs_out_next = 1'b0;
                    end else if (phase_reg < READ_RELEASE_PHASE) begin
                        dq_out_next  = rd_word_reg[(phase_reg - 3'h1)*DQ_WIDTH +: DQ_WIDTH];
                        dqs_out_next = phase_reg[0];
                    end else begin
                        drive_next   = 1'b0;
                        dqs_out_next = 1'b0;
                        state_next   = ST_IDLE;
                    end
                end
            end
            ST_WRITE: begin
                if (dqs_edge) begin
                    beat_next = beat_reg + 3'h1;
                    wr_word_next[beat_reg[1:0]*DQ_WIDTH +: DQ_WIDTH] = dq_s;
                    // ball is the mask only while the redundant strobe is off
                    wr_mask_next[beat_reg[1:0]] = mask_s & ~rrs_en_reg[rank_reg];
                    if (beat_reg == 3'(BURST_BEATS - 1)) begin
                        mem_we     = 1'b1;
                        mem_wdata  = merge_masked(mem[rank_reg][index_reg], wr_word_next, wr_mask_next);
                        state_next = ST_IDLE;
                    end
                end else if (ck_edge) begin
                    // a burst with missing strobes is dropped, not left hanging
                    phase_next = phase_reg + 3'h1;
                    if (phase_reg == 3'(WRITE_TIMEOUT_EDGES - 1)) begin
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
                drive_next = 1'b0;
            end
        endcase
        dqsc_out_next = ~dqs_out_next;
        dqsc_oe_next  = drive_next & ~cdis_next[rank_next];
        rrs_oe_next   = drive_next & rrs_en_next[rank_next];
        rrsc_oe_next  = rrs_oe_next & ~cdis_next[rank_next];
    end

    always_ff @(posedge i_core_clk) begin
        if (mem_we) begin
            mem[rank_reg][index_reg] <= mem_wdata;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            state_reg    <= ST_IDLE;
            phase_reg    <= 3'h0;
            beat_reg     <= 3'h0;
            rank_reg     <= 1'b0;
            index_reg    <= '0;
            rd_word_reg  <= '0;
            wr_word_reg  <= '0;
            wr_mask_reg  <= 4'h0;
            cdis_reg     <= {RANKS{COMPLEMENT_DISABLE_RST}};
            rrs_en_reg   <= {RANKS{REDUNDANT_ENABLE_RST}};
            ck_prev_reg  <= 1'b0;
            dqs_prev_reg <= 1'b0;
            dq_out_reg   <= '0;
            drive_reg    <= 1'b0;
            dqs_out_reg  <= 1'b0;
            dqsc_out_reg <= 1'b1;
            dqsc_oe_reg  <= 1'b0;
            rrs_oe_reg   <= 1'b0;
            rrsc_oe_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            phase_reg    <= phase_next;
            beat_reg     <= beat_next;
            rank_reg     <= rank_next;
            index_reg    <= index_next;
            rd_word_reg  <= rd_word_next;
            wr_word_reg  <= wr_word_next;
            wr_mask_reg  <= wr_mask_next;
            cdis_reg     <= cdis_next;
            rrs_en_reg   <= rrs_en_next;
            ck_prev_reg  <= ck_prev_next;
            dqs_prev_reg <= dqs_prev_next;
            dq_out_reg   <= dq_out_next;
            drive_reg    <= drive_next;
            dqs_out_reg  <= dqs_out_next;
            dqsc_out_reg <= dqsc_out_next;
            dqsc_oe_reg  <= dqsc_oe_next;
            rrs_oe_reg   <= rrs_oe_next;
            rrsc_oe_reg  <= rrsc_oe_next;
        end
    end

    assign o_dq                                  = dq_out_reg;
    assign o_dq_oe                               = drive_reg;
    assign o_dqs                                 = dqs_out_reg;
    assign o_dqs_oe                              = drive_reg;
    assign o_dqs_complement                      = dqsc_out_reg;
    assign o_dqs_complement_oe                   = dqsc_oe_reg;
    assign o_redundant_read_strobe               = dqs_out_reg;
    assign o_redundant_read_strobe_oe            = rrs_oe_reg;
    assign o_redundant_read_strobe_complement    = dqsc_out_reg;
    assign o_redundant_read_strobe_complement_oe = rrsc_oe_reg;
    assign o_strobe_complement_enabled           = ~cdis_reg;
    assign o_redundant_strobe_enabled            = rrs_en_reg;
    assign o_busy                                = (state_reg != ST_IDLE);
endmodule // ddr2_two_rank_strobe_datapath

/* File: ddr2_strobe_checker.sv */
// read-drive assertions for the two-rank ddr2 strobe datapath
`timescale 1ns/1ns
module ddr2_strobe_checker #(
    parameter int DQ_WIDTH = 8
) (
    input  wire logic                i_core_clk,
    input  wire logic                i_reset,
    input  wire logic [DQ_WIDTH-1:0] o_dq,
    input  wire logic                o_dq_oe,
    input  wire logic                o_dqs,
    input  wire logic                o_dqs_oe,
    input  wire logic                o_dqs_complement,
    input  wire logic                o_dqs_complement_oe,
    input  wire logic                o_redundant_read_strobe,
    input  wire logic                o_redundant_read_strobe_oe,
    input  wire logic                o_redundant_read_strobe_complement,
    input  wire logic                o_redundant_read_strobe_complement_oe,
    input  wire logic                o_busy
);
    logic [2:0] toggles_reg;
    logic [2:0] toggles_next;
    logic       dqs_prev_reg;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // strobe toggles counted per drive window
    always_comb begin
        toggles_next = o_dq_oe ? toggles_reg + 3'(o_dqs != dqs_prev_reg) : 3'h0;
    end
    always_ff @(posedge i_core_clk) begin
        toggles_reg  <= i_reset ? 3'h0 : toggles_next;
        dqs_prev_reg <= i_reset ? 1'b0 : o_dqs;
    end
    sequence s_first_beat;
        !o_dqs ##[2:10] ($rose(o_dqs) && o_dq_oe);
    endsequence
    sequence s_half_beat;
        ##1 $stable(o_dqs)[*2] ##[0:8] ($changed(o_dqs) || !o_dq_oe);
    endsequence
    AST_READ_PREAMBLE: assert property ($rose(o_dq_oe) |-> s_first_beat)
        else $error("read drive did not open low then rise");
    AST_EDGE_ALIGNED: assert property (o_dq_oe && $past(o_dq_oe) && $changed(o_dq) |-> $changed(o_dqs))
        else $error("read data moved without a strobe edge");
    AST_HALF_CYCLE: assert property (o_dq_oe && $changed(o_dqs) |-> s_half_beat)
        else $error("read strobe spacing is not one half cycle");
    AST_FOUR_BEATS: assert property ($fell(o_dq_oe) |-> toggles_reg == 3'h4)
        else $error("read burst did not carry four beats");
    AST_DRIVE_IN_BURST: assert property ((o_dq_oe || o_dqs_oe) |-> o_busy && (o_dq_oe == o_dqs_oe))
        else $error("data and strobe drive disagree or drive outside a burst");
    AST_DQS_COMP: assert property (o_dqs_complement_oe |-> o_dqs_oe && (o_dqs_complement != o_dqs))
        else $error("strobe complement is not the inverse of the strobe");
    AST_RRS_READ_ONLY: assert property (o_redundant_read_strobe_oe |-> o_dq_oe && (o_redundant_read_strobe == o_dqs))
        else $error("redundant strobe driven apart from read data");
    AST_RRS_COMP: assert property (o_redundant_read_strobe_complement_oe
        |-> o_redundant_read_strobe_oe && o_dqs_complement_oe
        && (o_redundant_read_strobe_complement != o_redundant_read_strobe))
        else $error("redundant complement driven without both modes or not inverted");
endmodule // ddr2_strobe_checker

bind ddr2_two_rank_strobe_datapath ddr2_strobe_checker #(.DQ_WIDTH(DQ_WIDTH)) ddr2_strobe_checker_i (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_dqs(o_dqs),
    .o_dqs_oe(o_dqs_oe), .o_dqs_complement(o_dqs_complement), .o_dqs_complement_oe(o_dqs_complement_oe),
    .o_redundant_read_strobe(o_redundant_read_strobe), .o_redundant_read_strobe_oe(o_redundant_read_strobe_oe),
    .o_redundant_read_strobe_complement(o_redundant_read_strobe_complement),
    .o_redundant_read_strobe_complement_oe(o_redundant_read_strobe_complement_oe), .o_busy(o_busy));

/* File: ddr2_ctrl_model.sv */
// controller-side partner: link clock, commands and write bursts
`timescale 1ns/1ns
module ddr2_ctrl_model
    import ddr2_strobe_pkg::*;
(
    input  wire logic        i_core_clk,
    input  wire logic        i_run,
    output logic             o_ck,
    output logic [RANKS-1:0] o_cs_n,
    output logic [2:0]       o_cmd,
    output logic [2:0]       o_ba,
    output logic [13:0]      o_addr,
    output logic [7:0]       o_dq,
    output logic             o_dqs,
    output logic             o_mask
);
    logic [1:0] div = 2'h0;
    initial begin
        o_ck   = 1'b0;
        o_cs_n = 2'h3;
        o_cmd  = 3'h7;
        o_ba   = 3'h0;
        o_addr = 14'h0000;
        o_dq   = 8'h00;
        o_dqs  = 1'b1;
        o_mask = 1'b0;
    end
    // held low until started, then free running at four core cycles a half period
    always @(posedge i_core_clk) begin
        if (i_run) begin
            div <= div + 2'h1;
            if (div == 2'h3) o_ck <= ~o_ck;
        end
    end
    // command lines change on ck fall so they straddle the rise with margin
    task automatic command(input logic [1:0] cs, input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
        @(negedge o_ck);
        @(posedge i_core_clk);
        o_cs_n <= cs;
        o_cmd  <= c;
        o_ba   <= b;
        o_addr <= a;
        @(negedge o_ck);
        @(posedge i_core_clk);
        o_cs_n <= 2'h3;
        o_cmd  <= 3'h7;
    endtask
    task automatic write(input logic [1:0] cs, input logic [2:0] b, input logic [13:0] a,
                         input logic [31:0] w, input logic [3:0] m);
        @(posedge i_core_clk);
        o_dqs <= 1'b0;
        command(cs, CMD_WRITE, b, a);
        for (int k = 0; k < BURST_BEATS; k++) begin
            o_dq   <= w[k*8 +: 8];
            o_mask <= m[k];
            repeat (3) @(posedge i_core_clk);
            o_dqs  <= ~o_dqs;
            repeat (3) @(posedge i_core_clk);
        end
        // released lines flip so a stale value cannot pass for data
        o_dq   <= ~o_dq;
        o_mask <= ~o_mask;
        o_dqs  <= 1'b1;
    endtask
endmodule // ddr2_ctrl_model

/* File: tb_top.sv */
// self-checking bench for the two-rank ddr2 strobe datapath
`timescale 1ns/1ns
module tb_top
    import ddr2_strobe_pkg::*;
;
    localparam logic [31:0] W0  = 32'hA5C3_1E7F;
    localparam logic [31:0] W1  = 32'h5A3C_E187;
    localparam logic [31:0] W2  = 32'h1234_5678;
    localparam logic [31:0] W2M = 32'h123C_5678; // beat two kept from W1
    logic             i_core_clk = 1'b0;
    logic             i_reset    = 1'b1;
    logic             run        = 1'b0;
    logic             ck, dqs_m, mask_m, o_dq_oe, o_dqs, o_dqs_oe, o_dqs_complement_oe, rrs, rrs_oe, rrs_c_oe, o_busy;
    logic [RANKS-1:0] cs_n, comp_en, red_en;
    logic [2:0]       cmd, ba;
    logic [13:0]      addr;
    logic [7:0]       dq_m, o_dq;
    int               fails        = 0;
    int               total_checks = 0;
    wire logic [7:0]  dq_w  = o_dq_oe ? o_dq : dq_m;
    wire logic        dqs_w = o_dqs_oe ? o_dqs : dqs_m;
    wire logic        b3_w  = rrs_oe ? rrs : mask_m;
    always #25 i_core_clk = ~i_core_clk;
    ddr2_ctrl_model ddr2_ctrl_model_i (.i_core_clk(i_core_clk), .i_run(run), .o_ck(ck), .o_cs_n(cs_n), .o_cmd(cmd),
        .o_ba(ba), .o_addr(addr), .o_dq(dq_m), .o_dqs(dqs_m), .o_mask(mask_m));
    ddr2_two_rank_strobe_datapath #(.DQ_WIDTH(8), .INDEX_BITS(5)) ddr2_two_rank_strobe_datapath_i (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_ck(ck), .i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]),
        .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr), .i_dq(dq_w), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dqs(dqs_w),
        .o_dqs(o_dqs), .o_dqs_oe(o_dqs_oe), .i_dqs_complement(~dqs_w), .o_dqs_complement(),
        .o_dqs_complement_oe(o_dqs_complement_oe), .i_write_byte_mask(b3_w), .o_redundant_read_strobe(rrs),
        .o_redundant_read_strobe_oe(rrs_oe), .i_redundant_read_strobe_complement(~b3_w),
        .o_redundant_read_strobe_complement(), .o_redundant_read_strobe_complement_oe(rrs_c_oe),
        .o_strobe_complement_enabled(comp_en), .o_redundant_strobe_enabled(red_en), .o_busy(o_busy));
    task automatic tick;
        @(posedge i_core_clk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        tick;
        while (o_busy !== 1'b0 && n < 60) begin
            tick;
            n++;
        end
        if (n >= 60) chk(32'(o_busy), 32'h0000_0000);
    endtask
    task automatic ld(input logic [1:0] cs, input logic [13:0] a, input logic [3:0] exp);
        wait_idle;
        ddr2_ctrl_model_i.command(cs, CMD_LOAD_MODE, EXT_CONFIG_BANK, a);
        tick;
        chk(32'({comp_en, red_en}), 32'(exp));
    endtask
    task automatic wr(input logic [1:0] cs, input logic [31:0] w, input logic [3:0] m);
        wait_idle;
        ddr2_ctrl_model_i.write(cs, 3'h2, 14'h0004, w, m);
    endtask
    // gathers four beats on strobe edges; optional strobe enables sampled on the first beat
    task automatic rd(input logic [1:0] cs, input logic [31:0] exp, input logic [2:0] exp_oe);
        logic [31:0] got;
        logic        prev;
        int          n;
        got = 32'h0000_0000;
        n = 0;
        wait_idle;
        ddr2_ctrl_model_i.command(cs, CMD_READ, 3'h2, 14'h0004);
        while (o_dq_oe !== 1'b1 && n < 40) begin
            tick;
            n++;
        end
        for (int k = 0; k < BURST_BEATS; k++) begin
            prev = o_dqs;
            n = 0;
            do begin
                tick;
                n++;
            end while (o_dqs === prev && n < 20);
            got[k*8 +: 8] = o_dq;
            if (k == 0) chk(32'({o_dqs_complement_oe, rrs_oe, rrs_c_oe}), 32'(exp_oe));
        end
        chk(got, exp);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        end_of_test;
    end
    initial begin
        repeat (10) @(posedge i_core_clk);
        #1;
        chk(32'({comp_en, red_en, o_dq_oe, o_busy}), 32'h0000_0000);
        @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        run <= 1'b1;
        $display("test reset done");
        ld(2'h1, 14'h0000, 4'h8);
        ld(2'h2, 14'h0800, 4'hD);
        ld(2'h1, 14'h0400, 4'h5);
        ld(2'h3, 14'h0800, 4'h5);
        $display("test mode loads done");
        wr(2'h2, W0, 4'h2);
        wr(2'h1, W1, 4'h0);
        wr(2'h1, W2, 4'h4);
        rd(2'h2, W0, 3'h7);
        rd(2'h1, W2M, 3'h0);
        // strobeless write burst must time out and leave the word alone
        wait_idle;
        ddr2_ctrl_model_i.command(2'h1, CMD_WRITE, 3'h2, 14'h0004);
        repeat (20) tick;
        chk(32'(o_busy), 32'h0000_0001);
        rd(2'h1, W2M, 3'h0);
        $display("test write read done");
        wait_idle;
        ddr2_ctrl_model_i.command(2'h3, CMD_READ, 3'h2, 14'h0004);
        repeat (8) tick;
        chk(32'({o_busy, o_dq_oe}), 32'h0000_0000);
        $display("test deselected read done");
        end_of_test;
    end
endmodule // tb_top
